// ===== tcc_channel.sv
// Transfer controller channel: one control-data set moving blocks on conversion end.
// Assumes an APB master on pclk and a memory port that answers with mem_ack.
`timescale 1ns/10ps
`include "tcc_params.svh"
module tcc_channel
   import tcc_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Conversion end event from the converter
   input  wire logic        conv_end,
   // Memory port
   output tcc_mem_req_t     mem_req,
   input  wire logic        mem_ack,
   input  wire logic [15:0] mem_rdata,
   // Chain request and interrupt
   output logic             chain_req,
   output logic             irq
);

   // ==========================================
   // Registers
   logic [7:0]  ctl_ff, bls_ff, cnt_ff, rld_ff, act_ff;
   logic [15:0] sar_ff, dar_ff, sar_base_ff, dar_base_ff;
   logic [2:0]  ist_ff, ien_ff;
   logic [8:0]  unit_left_ff;
   logic [15:0] data_ff;
   tcc_state_t  state_ff;
   tcc_mem_req_t req_ff;
   logic        chain_ff;
   logic [31:0] rdata_ff;

   tcc_ctl_t ctl;
   assign ctl = tcc_ctl_t'(ctl_ff[6:0]);

   // ==========================================
   // Event input
   logic conv_sync, conv_pulse;

   tcc_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (conv_end),
      .dout    (conv_sync)
   );

   tcc_ev_detect u_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (conv_sync),
      .pulse   (conv_pulse)
   );

   // ==========================================
   // APB decode
   wire wr_en  = psel & penable & pwrite;
   wire rd_en  = psel & penable & ~pwrite;
   wire hit_ctl = paddr == `TCC_OFF_CONTROL;
   wire hit_bls = paddr == `TCC_OFF_BLOCK_SIZE;
   wire hit_cnt = paddr == `TCC_OFF_COUNT;
   wire hit_rld = paddr == `TCC_OFF_RELOAD;
   wire hit_sar = paddr == `TCC_OFF_SRC_ADDR;
   wire hit_dar = paddr == `TCC_OFF_DST_ADDR;
   wire hit_act = paddr == `TCC_OFF_ACT_EN;
   wire hit_ist = paddr == `TCC_OFF_IRQ_STATUS;
   wire hit_ien = paddr == `TCC_OFF_IRQ_ENABLE;
   wire hit_icl = paddr == `TCC_OFF_IRQ_CLEAR;
   wire hit_sta = paddr == `TCC_OFF_STATE;
   wire hit_any = hit_ctl | hit_bls | hit_cnt | hit_rld | hit_sar | hit_dar
                | hit_act | hit_ist | hit_ien | hit_icl | hit_sta;
   wire busy    = state_ff != TCC_IDLE;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   assign prdata  = rdata_ff;

   // Read mux, registered on setup so data stands in the access phase
   wire [31:0] rd_mux =
        hit_ctl ? {24'h000000, ctl_ff} :
        hit_bls ? {24'h000000, bls_ff} :
        hit_cnt ? {24'h000000, cnt_ff} :
        hit_rld ? {24'h000000, rld_ff} :
        hit_sar ? {16'h0000, sar_ff} :
        hit_dar ? {16'h0000, dar_ff} :
        hit_act ? {24'h000000, act_ff} :
        hit_ist ? {29'h00000000, ist_ff} :
        hit_ien ? {29'h00000000, ien_ff} :
        hit_sta ? {28'h0000000, state_ff} : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         rdata_ff <= rd_mux;
      end
   end

   // ==========================================
   // Transfer decisions
   wire trig      = conv_pulse & act_ff[`TCC_ACT_CONV_BIT] & ~busy;
   wire rpt_src   = ctl.repeat_mode & ctl.rpt_src;
   wire rpt_dst   = ctl.repeat_mode & ~ctl.rpt_src;
   // A source repeat area always steps; the step bit only rules a plain source
   wire src_inc   = (ctl.src_step & ~rpt_src) | rpt_src;
   wire dst_inc   = ctl.dst_step | rpt_dst;
   wire [15:0] step = ctl.wide ? 16'h0002 : 16'h0001;
   wire [8:0]  blk_units = (bls_ff == 8'h00) ? 9'h100 : {1'b0, bls_ff};
   wire last_unit = unit_left_ff == 9'h001;
   wire cnt_last  = cnt_ff == 8'h01;                     // 00H counts as 256
   wire done_now  = state_ff == TCC_DONE;
   wire end_cond  = done_now & cnt_last & (~ctl.repeat_mode | ctl.rpt_irq);
   wire rpt_wrap  = done_now & cnt_last & ctl.repeat_mode;
   wire chain_go  = done_now & ctl.chain;
   wire [2:0] ev_set = {chain_go, rpt_wrap & ctl.rpt_irq, end_cond};

   // ==========================================
   // Transfer state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff     <= TCC_IDLE;
         unit_left_ff <= 9'h000;
         data_ff      <= 16'h0000;
      end else begin
         unique case (state_ff)
            TCC_IDLE: begin
               if (trig) begin
                  state_ff     <= TCC_READ;
                  unit_left_ff <= blk_units;
               end
            end
            TCC_READ: begin
               if (mem_ack) begin
                  data_ff  <= mem_rdata;
                  state_ff <= TCC_WRITE;
               end
            end
            TCC_WRITE: begin
               if (mem_ack) begin
                  unit_left_ff <= unit_left_ff - 9'h001;
                  state_ff     <= last_unit ? TCC_DONE : TCC_READ;
               end
            end
            TCC_DONE: begin
               state_ff <= TCC_IDLE;
            end
         endcase
      end
   end

   // Memory request built from the state and the live addresses
   always_comb begin
      mem_req       = '0;
      mem_req.wide  = ctl.wide;
      mem_req.wdata = data_ff;
      if (state_ff == TCC_READ) begin
         mem_req.rd   = 1'b1;
         mem_req.addr = sar_ff;
      end else if (state_ff == TCC_WRITE) begin
         mem_req.wr   = 1'b1;
         mem_req.addr = dar_ff;
      end
   end

   // ==========================================
   // Software registers with hardware updates
   wire rd_step = state_ff == TCC_READ & mem_ack;
   wire wr_step = state_ff == TCC_WRITE & mem_ack;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_ff      <= `TCC_RST_BYTE;
         bls_ff      <= `TCC_RST_BYTE;
         cnt_ff      <= `TCC_RST_BYTE;
         rld_ff      <= `TCC_RST_BYTE;
         act_ff      <= `TCC_RST_BYTE;
         sar_ff      <= `TCC_RST_ADDR;
         dar_ff      <= `TCC_RST_ADDR;
         sar_base_ff <= `TCC_RST_ADDR;
         dar_base_ff <= `TCC_RST_ADDR;
         ien_ff      <= `TCC_RST_IRQ;
      end else begin
         // Block settings, but not the interrupt enable, are frozen during a block so a half-moved block stays coherent
         if (wr_en & hit_ctl & ~busy) ctl_ff <= pwdata[7:0] & `TCC_CTL_MASK;
         if (wr_en & hit_bls & ~busy) bls_ff <= pwdata[7:0];
         if (wr_en & hit_rld & ~busy) rld_ff <= pwdata[7:0];
         if (wr_en & hit_ien)         ien_ff <= pwdata[2:0];
         if (wr_en & hit_sar & ~busy) begin
            sar_ff      <= pwdata[15:0];
            sar_base_ff <= pwdata[15:0];
         end else if (rpt_wrap & rpt_src) begin
            sar_ff      <= sar_base_ff;
         end else if (rd_step & src_inc) begin
            sar_ff      <= sar_ff + step;
         end
         if (wr_en & hit_dar & ~busy) begin
            dar_ff      <= pwdata[15:0];
            dar_base_ff <= pwdata[15:0];
         end else if (rpt_wrap & rpt_dst) begin
            dar_ff      <= dar_base_ff;
         end else if (wr_step & dst_inc) begin
            dar_ff      <= dar_ff + step;
         end
         if (wr_en & hit_cnt & ~busy) begin
            cnt_ff <= pwdata[7:0];
         end else if (rpt_wrap) begin
            cnt_ff <= rld_ff;
         end else if (done_now) begin
            cnt_ff <= cnt_ff - 8'h01;
         end
         // Hardware clear wins over a same-cycle software set
         if (end_cond) begin
            act_ff[`TCC_ACT_CONV_BIT] <= 1'b0;
         end else if (wr_en & hit_act) begin
            act_ff <= pwdata[7:0];
         end
      end
   end

   // ==========================================
   // Interrupt status, enable and clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_ff   <= `TCC_RST_IRQ;
         chain_ff <= 1'b0;
      end else begin
         ist_ff   <= (ist_ff & ~((wr_en & hit_icl) ? pwdata[2:0] : 3'h0)) | ev_set;
         chain_ff <= chain_go;
      end
   end

   assign chain_req = chain_ff;
   assign irq       = |(ist_ff & ien_ff);

endmodule

// ===== tcc_channel_tb.sv
// Self-checking bench for the transfer channel.
// Assumes the design, package, header, memory model and checker files.
`timescale 1ns/10ps
`include "tcc_params.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module tcc_channel_tb
   import tcc_pkg::*;
   ;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic         conv_end, mem_ack, chain_req, irq, e;
   logic [3:0]   lat;
   logic [11:0]  paddr;
   logic [15:0]  mem_rdata;
   logic [31:0]  pwdata, prdata, q;
   tcc_mem_req_t mem_req;
   int           fails, total_checks;
   tcc_channel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_end(conv_end), .mem_req(mem_req), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .chain_req(chain_req), .irq(irq));
   tcc_mem_model i_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat));
   initial begin
      pclk = 1'h0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic tally_and_finish();
      if (fails == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==========================================
   // Bus and event drivers
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'h1) break;
      end
      q = prdata;
      e = pslverr;
      if (n >= 16) begin
         fails++;
         tally_and_finish();
      end
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic cfg(input logic [31:0] c, b, n, s, d);
      apb(1'h1, `TCC_OFF_CONTROL, c);
      apb(1'h1, `TCC_OFF_BLOCK_SIZE, b);
      apb(1'h1, `TCC_OFF_COUNT, n);
      apb(1'h1, `TCC_OFF_SRC_ADDR, s);
      apb(1'h1, `TCC_OFF_DST_ADDR, d);
      apb(1'h1, `TCC_OFF_ACT_EN, 32'h20);
   endtask
   task automatic fire(input int wait_n);
      conv_end <= 1'h1;
      repeat (2) @(posedge pclk);
      conv_end <= 1'h0;
      for (int k = 0; k < 4000 && i_mem.wlog.size() < wait_n; k++) @(posedge pclk);
      if (i_mem.wlog.size() < wait_n) begin
         fails++;
         tally_and_finish();
      end
      // The done cycle follows the last write
      repeat (12) @(posedge pclk);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_regs();
      for (int i = 0; i < 7; i++) begin
         apb(1'h0, 12'(4 * i), 32'h0);
         `CHK("reset value", 32'h0, q)
      end
      fire(0);
      `CHK("blocked", 0, i_mem.wlog.size())
      apb(1'h1, `TCC_OFF_CONTROL, 32'hFF);
      apb(1'h0, `TCC_OFF_CONTROL, 32'h0);
      `CHK("control", 32'h7F, q)
      apb(1'h0, 12'h040, 32'h0);
      `CHK("unmapped", 1'h1, e)
   endtask
   task automatic t_normal();
      apb(1'h1, `TCC_OFF_IRQ_ENABLE, 32'h1);
      cfg(32'h4C, 32'h2, 32'h1, 32'h1000, 32'h2000);
      fire(2);
      `CHK("unit 0", {1'h1, 16'h2000, ~16'h1000}, i_mem.wlog[0])
      `CHK("unit 1", {1'h1, 16'h2002, ~16'h1002}, i_mem.wlog[1])
      apb(1'h0, `TCC_OFF_COUNT, 32'h0);
      `CHK("count", 32'h0, q)
      apb(1'h0, `TCC_OFF_ACT_EN, 32'h0);
      `CHK("act cleared", 32'h0, q)
      `CHK("irq", 1'h1, irq)
      apb(1'h1, `TCC_OFF_IRQ_CLEAR, 32'h7);
      `CHK("irq cleared", 1'h0, irq)
   endtask
   task automatic t_repeat();
      lat <= 4'h2;
      i_mem.wlog.delete();
      apb(1'h1, `TCC_OFF_IRQ_ENABLE, 32'h0);
      apb(1'h1, `TCC_OFF_RELOAD, 32'h2);
      cfg(32'h71, 32'h1, 32'h2, 32'h3000, 32'h4000);
      fire(1);
      apb(1'h0, `TCC_OFF_ACT_EN, 32'h0);
      `CHK("act kept", 32'h20, q)
      fire(2);
      `CHK("fixed source", {1'h1, 16'h4002, ~16'h3000}, i_mem.wlog[1])
      apb(1'h0, `TCC_OFF_COUNT, 32'h0);
      `CHK("reloaded", 32'h2, q)
      apb(1'h0, `TCC_OFF_DST_ADDR, 32'h0);
      `CHK("area restored", 32'h4000, q)
      apb(1'h0, `TCC_OFF_IRQ_STATUS, 32'h0);
      `CHK("status", 32'h7, q)
      `CHK("masked", 1'h0, irq)
      apb(1'h1, `TCC_OFF_IRQ_ENABLE, 32'h2);
      `CHK("enabled", 1'h1, irq)
      apb(1'h1, `TCC_OFF_IRQ_CLEAR, 32'h7);
      fire(0);
      `CHK("no restart", 2, i_mem.wlog.size())
   endtask
   task automatic t_byte();
      logic [32:0] w;
      lat <= 4'h1;
      i_mem.wlog.delete();
      cfg(32'h06, 32'h0, 32'h0, 32'h5000, 32'h6000);
      fire(256);
      w = i_mem.wlog[255];
      `CHK("units", 256, i_mem.wlog.size())
      `CHK("last unit", {1'h0, 16'h6000, 8'h00}, {w[32:16], w[7:0]})
      apb(1'h0, `TCC_OFF_COUNT, 32'h0);
      `CHK("count", 32'hFF, q)
      apb(1'h0, `TCC_OFF_ACT_EN, 32'h0);
      `CHK("act kept", 32'h20, q)
   endtask
   task automatic t_rpt_src();
      i_mem.wlog.delete();
      cfg(32'h4B, 32'h2, 32'h2, 32'h7000, 32'h8000);
      fire(2);
      `CHK("source area steps", {1'h1, 16'h8002, ~16'h7002}, i_mem.wlog[1])
      apb(1'h0, `TCC_OFF_COUNT, 32'h0);
      `CHK("count left", 32'h1, q)
   endtask
   initial begin
      {presetn, psel, penable, pwrite, conv_end} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      lat = 4'h0;
      fails = 0;
      total_checks = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_regs();
      t_normal();
      t_repeat();
      t_byte();
      t_rpt_src();
      tally_and_finish();
   end
endmodule
bind tcc_channel tcc_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .conv_end(conv_end), .mem_req(mem_req),
   .mem_ack(mem_ack), .mem_rdata(mem_rdata), .chain_req(chain_req), .irq(irq));

// ===== tcc_chk.sv
// Port-level checks for the transfer channel.
// Assumes a bind from the bench; sees only top ports.
`timescale 1ns/10ps
module tcc_chk
   import tcc_pkg::*;
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Event, memory, outputs
   input wire logic        conv_end,
   input tcc_mem_req_t     mem_req,
   input wire logic        mem_ack,
   input wire logic [15:0] mem_rdata,
   input wire logic        chain_req,
   input wire logic        irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // Memory port
   sequence rd_done_s;
      mem_req.rd && mem_ack;
   endsequence
   sequence blk_start_s;
      $rose(mem_req.rd) && !$past(mem_req.wr);
   endsequence
   one_access_a: assert property (!(mem_req.rd && mem_req.wr))
      else $error("read and write together");
   req_hold_a: assert property ((mem_req.rd || mem_req.wr) && !mem_ack |=> $stable(mem_req))
      else $error("request moved before ack");
   rd_to_wr_a: assert property (rd_done_s |=> mem_req.wr)
      else $error("read not followed by write");
   wide_keep_a: assert property (rd_done_s |=> mem_req.wide == $past(mem_req.wide))
      else $error("unit width changed");
   wr_once_a: assert property (mem_req.wr && mem_ack |=> !mem_req.wr)
      else $error("write repeated");
   // A block start is only caused by a recent conversion end
   start_cause_a: assert property (blk_start_s |-> $past(conv_end, 2) || $past(conv_end, 3))
      else $error("block started without event");
   chain_pulse_a: assert property (chain_req |=> !chain_req)
      else $error("chain request too long");
   chain_cause_a: assert property (chain_req |-> $past(mem_req.wr && mem_ack, 2))
      else $error("chain request without block end");
endmodule

// ===== tcc_ev_detect.sv
// Rising edge detector on a synchronised event level.
// Assumes its input is already in the pclk domain.
`timescale 1ns/10ps
module tcc_ev_detect
   import tcc_pkg::*;
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Event
   input  wire logic level,
   output logic      pulse
);
   logic prev_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= level;
      end
   end

   assign pulse = level & ~prev_ff;
endmodule

// ===== tcc_mem_model.sv
// Result register and RAM stand-in on the memory port.
// Assumes requests hold until mem_ack; lat sets waits per access.
`timescale 1ns/10ps
module tcc_mem_model
   import tcc_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Memory port
   input  tcc_mem_req_t    mem_req,
   output logic            mem_ack,
   output logic [15:0]     mem_rdata,
   // Wait states
   input  wire logic [3:0] lat
);
   logic [3:0]  cnt_ff;
   logic        tog_ff;
   logic        busy;
   logic [15:0] rval;
   logic [32:0] wlog[$];
   assign busy    = mem_req.rd | mem_req.wr;
   assign mem_ack = busy && (cnt_ff >= lat);
   // Byte reads repeat the byte so either lane carries it
   assign rval = mem_req.wide ? ~mem_req.addr : {2{~mem_req.addr[7:0]}};
   // Idle data toggles so a stale capture shows up
   assign mem_rdata = (mem_ack && mem_req.rd) ? rval : {16{tog_ff}};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 4'h0;
         tog_ff <= 1'h0;
      end else begin
         cnt_ff <= mem_ack ? 4'h0 : cnt_ff + {3'h0, busy};
         tog_ff <= ~tog_ff;
      end
   end
   always @(posedge pclk) begin
      if (mem_ack && mem_req.wr) begin
         wlog.push_back({mem_req.wide, mem_req.addr, mem_req.wdata});
      end
   end
endmodule

// ===== tcc_params.svh
// Register offsets, field positions, the control mask and reset values of the transfer channel.
// Assumes inclusion by the channel and by its bench, the files that need these numbers.
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// ==========================================
// Register byte offsets on APB
`define TCC_OFF_CONTROL     12'h000
`define TCC_OFF_BLOCK_SIZE  12'h004
`define TCC_OFF_COUNT       12'h008
`define TCC_OFF_RELOAD      12'h00C
`define TCC_OFF_SRC_ADDR    12'h010
`define TCC_OFF_DST_ADDR    12'h014
`define TCC_OFF_ACT_EN      12'h018
`define TCC_OFF_IRQ_STATUS  12'h01C
`define TCC_OFF_IRQ_ENABLE  12'h020
`define TCC_OFF_IRQ_CLEAR   12'h024
`define TCC_OFF_STATE       12'h028

// ==========================================
// Control register fields
`define TCC_CTL_MODE        0
`define TCC_CTL_REPEAT_AREA_SELECT      1
`define TCC_CTL_SRC_STEP    2
`define TCC_CTL_DST_STEP    3
`define TCC_CTL_CHAIN       4
`define TCC_CTL_RPT_IRQ     5
`define TCC_CTL_SIZE        6
`define TCC_CTL_MASK        8'h7F

// Activation enable bit for conversion end
`define TCC_ACT_CONV_BIT    5

// Interrupt status bits
`define TCC_IRQ_END_BIT     0
`define TCC_IRQ_RPT_BIT     1
`define TCC_IRQ_CHAIN_BIT   2

// ==========================================
// Reset values
`define TCC_RST_BYTE        8'h00
`define TCC_RST_ADDR        16'h0000
`define TCC_RST_IRQ         3'h0

`endif

// ===== tcc_pkg.sv
// Types shared by the transfer channel files.
// Assumes tcc_params.svh sits in the same folder.
package tcc_pkg;

   // ==========================================
   // Memory side request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        wide;
      logic [15:0] addr;
      logic [15:0] wdata;
   } tcc_mem_req_t;

   // ==========================================
   // Decoded control fields
   typedef struct packed {
      logic wide;
      logic rpt_irq;
      logic chain;
      logic dst_step;
      logic src_step;
      logic rpt_src;
      logic repeat_mode;
   } tcc_ctl_t;

   typedef enum logic [3:0] {
      TCC_IDLE  = 4'b0001,
      TCC_READ  = 4'b0010,
      TCC_WRITE = 4'b0100,
      TCC_DONE  = 4'b1000
   } tcc_state_t;

endpackage

// ===== tcc_sync.sv
// Two flip-flop synchroniser for one level.
// Assumes the input comes from outside the pclk domain.
`timescale 1ns/10ps
module tcc_sync
   import tcc_pkg::*;
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Level
   input  wire logic din,
   output logic      dout
);
   logic meta_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= 1'b0;
         dout    <= 1'b0;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end
endmodule
